/* verilog/rss_defines.svh */
// Constants for the ROM state sequencer
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH
`define RSS_ADDR_W 8
`define RSS_NIB_W 4
`define RSS_ADDR_RESET 8'h00
`define RSS_ADDR_LAST 8'hff
`define RSS_NIB_LAST 4'hf
`define RSS_NIB_RESET 4'h0
`endif

/* verilog/rss_pkg.sv */
// Types for the ROM state sequencer
package rss_pkg;
  typedef enum logic {
    RSS_PROCESS,
    RSS_DECISION
  } rss_state_kind_t;
endpackage

/* verilog/rss_counter_half.sv */
// Four-bit counter half with parallel load and carry chain
`include "rss_defines.svh"
module rss_counter_half (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_count_en,
  input wire logic i_load_n,
  input wire logic [3:0] i_load_val,
  output logic [3:0] o_count,
  output logic o_carry
);
  logic [3:0] count_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      count_reg <= `RSS_NIB_RESET; // [R13]
    end else if (!i_load_n) begin
      count_reg <= i_load_val; // [R03]
    end else if (i_count_en) begin
      count_reg <= count_reg + 4'h1; // [R04]
    end
  end

  assign o_count = count_reg;
  assign o_carry = i_count_en && (count_reg == `RSS_NIB_LAST);
endmodule // rss_counter_half

/* verilog/rss_state_sequencer.sv */
// Eight-bit ROM-driven state sequencer
`include "rss_defines.svh"
// Function
// [R01] Eight-bit address counts up by one per clock, wrapping 255 to zero.
// [R02] Address built from two cascaded four-bit counter halves on one clock.
// [R03] A taken jump loads the ROM jump address in parallel.
// [R04] Without a jump the next address is present address plus one.
// [R05] Active-low load enable asserts only in decision state with jump condition.
// [R06] ROM format bit is high in decision states; jumps need it.
// [R07] Jump qualifies only when qualifier and polarity bit differ.
// [R08] Process-state flags matter only when later decision states test them.
// [R09] Format bit low forces advance by exactly one next edge.
// [R10] Normal decision jumps on high qualifier, else advances.
// [R11] Inverted decision jumps on low qualifier, advances on high.
// [R12] Increments and loads take effect at the next rising clock edge.
// [R13] Synchronous reset forces the address to zero.
module rss_state_sequencer (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_rom_format,
  input wire logic i_rom_polarity,
  input wire logic [7:0] i_rom_jump_addr,
  input wire logic i_qualifier,
  output logic [7:0] o_state_addr,
  output logic o_jump_taken
);
  ////////////////////////////////////////////////////////////////////////////
  // Qualifier synchroniser
  logic qual_meta_reg;
  logic qual_sync_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      qual_meta_reg <= 1'b0;
      qual_sync_reg <= 1'b0;
    end else begin
      qual_meta_reg <= i_qualifier;
      qual_sync_reg <= qual_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jump decision
  rss_pkg::rss_state_kind_t kind;
  logic qual_met;
  logic jump_load_n;
  logic lo_carry;
  logic [3:0] lo_count;
  logic [3:0] hi_count;

  // Format bit low means a process state, which never branches
  assign kind = i_rom_format ? rss_pkg::RSS_DECISION : rss_pkg::RSS_PROCESS; // [R06] [R09] [R08]
  // Polarity low: jump on high qualifier; polarity high: jump on low
  assign qual_met = qual_sync_reg ^ i_rom_polarity; // [R07] [R10] [R11]
  assign jump_load_n = !((kind == rss_pkg::RSS_DECISION) && qual_met); // [R05]

  ////////////////////////////////////////////////////////////////////////////
  // Counter halves
  rss_counter_half u_lo (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_count_en(1'b1),
    .i_load_n(jump_load_n),
    .i_load_val(i_rom_jump_addr[3:0]),
    .o_count(lo_count),
    .o_carry(lo_carry)
  ); // [R02] [R12]

  rss_counter_half u_hi (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_count_en(lo_carry),
    .i_load_n(jump_load_n),
    .i_load_val(i_rom_jump_addr[7:4]),
    .o_count(hi_count),
    .o_carry()
  ); // [R02] [R01]

  assign o_state_addr = {hi_count, lo_count};

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_jump_taken <= 1'b0;
    end else begin
      o_jump_taken <= !jump_load_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Jump wanted: decision state with the qualifier unlike the polarity bit
  function automatic logic rss_jump_wanted(input logic fmt, input logic pol, input logic qual);
    return fmt && (qual != pol);
  endfunction

  sequence seq_decision_jump;
    rss_jump_wanted(i_rom_format, i_rom_polarity, qual_sync_reg);
  endsequence

  sequence seq_no_jump;
    !rss_jump_wanted(i_rom_format, i_rom_polarity, qual_sync_reg);
  endsequence

  sequence seq_process_state;
    !i_rom_format;
  endsequence

  sequence seq_normal_low;
    i_rom_format && !i_rom_polarity && !qual_sync_reg;
  endsequence

  sequence seq_inverted_high;
    i_rom_format && i_rom_polarity && qual_sync_reg;
  endsequence

  sequence seq_lo_mid;
    lo_count != `RSS_NIB_LAST;
  endsequence

  sequence seq_lo_last;
    lo_count == `RSS_NIB_LAST;
  endsequence

  sequence seq_addr_last;
    o_state_addr == `RSS_ADDR_LAST;
  endsequence

  sequence seq_out_of_reset;
    $past(i_reset_n);
  endsequence

  jump_loads_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R03]
    seq_decision_jump |=> o_state_addr == $past(i_rom_jump_addr))
    else $error("jump address not loaded");

  advance_one_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R04]
    seq_no_jump |=> o_state_addr == 8'($past(o_state_addr) + 8'h01))
    else $error("address did not advance by one");

  process_never_jumps_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R09]
    !i_rom_format |-> jump_load_n)
    else $error("jump in process state");

  load_only_decision_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R05]
    !jump_load_n |-> i_rom_format && qual_met)
    else $error("load enable without decision");

  equal_blocks_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R07]
    (qual_sync_reg == i_rom_polarity) |-> jump_load_n)
    else $error("jump with equal levels");

  normal_high_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R10]
    i_rom_format && !i_rom_polarity && qual_sync_reg |=> o_jump_taken)
    else $error("normal decision missed jump");

  inverted_low_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R11]
    i_rom_format && i_rom_polarity && !qual_sync_reg |=> o_jump_taken)
    else $error("inverted decision missed jump");

  wrap_zero_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R01]
    (seq_addr_last and seq_no_jump) |=> o_state_addr == `RSS_ADDR_RESET)
    else $error("address did not wrap");

  reset_zero_a: assert property (@(posedge i_mclk) // [R13]
    !i_reset_n |=> o_state_addr == `RSS_ADDR_RESET)
    else $error("reset did not clear address");

  // Address steps per state kind
  process_advance_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R09]
    seq_process_state |=> o_state_addr == 8'($past(o_state_addr) + 8'h01) && !o_jump_taken)
    else $error("process state did not advance by one");

  normal_low_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R10]
    seq_normal_low |=> o_state_addr == 8'($past(o_state_addr) + 8'h01) && !o_jump_taken)
    else $error("normal decision jumped on low qualifier");

  inverted_high_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R11]
    seq_inverted_high |=> o_state_addr == 8'($past(o_state_addr) + 8'h01) && !o_jump_taken)
    else $error("inverted decision jumped on high qualifier");

  no_jump_flag_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R04]
    seq_no_jump |=> !o_jump_taken)
    else $error("jump flag without jump");

  taken_flag_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R03]
    seq_decision_jump |=> o_jump_taken)
    else $error("jump flag missing after jump");

  // Counter halves
  lo_moves_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R02]
    seq_no_jump |=> lo_count == 4'($past(lo_count) + 4'h1))
    else $error("low half did not count");

  hi_holds_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R02]
    (seq_no_jump and seq_lo_mid) |=> hi_count == $past(hi_count))
    else $error("high half moved without carry");

  hi_carry_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R02]
    (seq_no_jump and seq_lo_last) |=> lo_count == `RSS_NIB_RESET && hi_count == 4'($past(hi_count) + 4'h1))
    else $error("carry did not reach high half");

  both_halves_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R03]
    seq_decision_jump |=> hi_count == $past(i_rom_jump_addr[7:4]) && lo_count == $past(i_rom_jump_addr[3:0]))
    else $error("jump did not load both halves");

  // Qualifier path and jump flag
  jump_flag_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R12]
    seq_out_of_reset |-> o_jump_taken == $past(!jump_load_n))
    else $error("jump flag not one edge after load");

  needs_format_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R06]
    (seq_out_of_reset and o_jump_taken) |-> $past(i_rom_format))
    else $error("jump taken without format bit");

  meta_follows_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R10]
    seq_out_of_reset |-> qual_meta_reg == $past(i_qualifier))
    else $error("first qualifier stage wrong");

  sync_follows_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R10]
    seq_out_of_reset |-> qual_sync_reg == $past(qual_meta_reg))
    else $error("second qualifier stage wrong");

  reset_flag_a: assert property (@(posedge i_mclk) // [R13]
    !i_reset_n |=> !o_jump_taken && !qual_sync_reg)
    else $error("reset did not clear flag or qualifier");
endmodule // rss_state_sequencer

/* dv/rss_rom_model.sv */
// Microcode ROM model with two decision states
module rss_rom_model (
  input wire logic [7:0] i_addr,
  output logic o_format,
  output logic o_polarity,
  output logic [7:0] o_jump_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // 8'h10 normal decision jumping onto 8'h20 inverted; process states carry a bait jump
  assign o_format = (i_addr == 8'h10) || (i_addr == 8'h20);
  assign o_polarity = (i_addr != 8'h10);
  assign o_jump_addr = (i_addr == 8'h10) ? 8'h20 : (i_addr == 8'h20) ? 8'h80 : 8'h55;
endmodule // rss_rom_model

/* dv/rss_state_sequencer_tb_top.sv */
// Self-checking bench for the state sequencer
module rss_state_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_qualifier = 1'b0;
  logic fmt;
  logic pol;
  logic jtk;
  logic ej;
  logic [7:0] jmp;
  logic [7:0] addr;
  logic [7:0] ea;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 i_mclk = ~i_mclk;
  rss_rom_model ROM (.i_addr(addr), .o_format(fmt), .o_polarity(pol), .o_jump_addr(jmp));
  rss_state_sequencer DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_rom_format(fmt),
    .i_rom_polarity(pol), .i_rom_jump_addr(jmp), .i_qualifier(i_qualifier),
    .o_state_addr(addr), .o_jump_taken(jtk));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset, then step 300 cycles through decisions, the jump target and the wrap
  task automatic run(input logic q);
    logic tk;
    i_reset_n = 1'b0;
    i_qualifier = q;
    repeat (3) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    ea = 8'h00;
    ej = 1'b0;
    repeat (300) begin
      chk8(addr, ea);
      chk1(jtk, ej);
      tk = fmt && (q != pol);
      ej = tk;
      ea = tk ? jmp : ea + 8'h01;
      @(posedge i_mclk);
      #1;
    end
  endtask
  task automatic s_normal_jump();
    run(1'b1);
  endtask
  task automatic s_inverted_jump();
    run(1'b0);
  endtask
  initial begin
    s_normal_jump();
    s_inverted_jump();
    end_of_test();
  end
endmodule // rss_state_sequencer_tb_top
